// *** can_mode_cfg.svh ***
// constants of the operating-mode controller
// assumes inclusion by bare name from the package and design modules
`ifndef CAN_MODE_CFG_SVH
`define CAN_MODE_CFG_SVH
`define REQ_MODE_MSB 10
`define REQ_MODE_LSB 8
`define CUR_MODE_MSB 7
`define CUR_MODE_LSB 5
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LISTEN_ALL 3'h7
`define MODE_INIT_DEFAULT 3'h4
`define MODE_LISTEN_ONLY_DEFAULT 3'h3
`define MODE_LOOPBACK_DEFAULT 3'h2
`define IDLE_BITS 4'hb
`define CFG_GROUPS 5
`endif

// *** can_mode_pkg.sv ***
// types of the operating-mode controller
// assumes can_mode_cfg.svh is on the include path
`include "can_mode_cfg.svh"
package can_mode_pkg;
	typedef enum logic [2:0] {
		ST_INIT,
		ST_DISABLE,
		ST_NORMAL,
		ST_LISTEN_ONLY,
		ST_LISTEN_ALL,
		ST_LOOPBACK
	} mode_e;
	typedef logic [2:0] code_t;
endpackage

// *** can_idle_detect.sv ***
// bus-idle detector: counts consecutive recessive sampled bits
// assumes BIT_TICK is a one-cycle pulse at the bit sample point
`timescale 1ns/1ps
`include "can_mode_cfg.svh"
module can_idle_detect (
	input wire logic CLK,
	input wire logic RST,
	input wire logic BIT_TICK,
	input wire logic RX_BIT,
	output logic IDLE
);
	typedef struct packed {
		logic [3:0] run;
		logic idle;
	} idle_s;
	idle_s q, next_q;
	always_comb begin
		next_q = q;
		if (BIT_TICK) begin
			if (!RX_BIT) begin
				next_q.run = 4'h0;
				next_q.idle = 1'b0;
			end else if (q.run != `IDLE_BITS) begin
				next_q.run = q.run + 4'h1;
				next_q.idle = (q.run + 4'h1) == `IDLE_BITS;
			end
		end
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end
	assign IDLE = q.idle;
	idle_after_run_a: assert property (@(posedge CLK) disable iff (RST)
		(BIT_TICK && !RX_BIT) |=> !IDLE) else $error("idle held after dominant bit");
endmodule

// *** can_operating_mode_control.sv ***
// operating-mode controller: requested vs current mode, idle-gated switching
// assumes bit tick, tx status and engine error from the bit engine on CLK;
// the rx pin itself is synchronised here
`timescale 1ns/1ps
`include "can_mode_cfg.svh"
// What this block does
// - software asks for a mode through the three-bit requested-mode field, bits 10 to 8 of control register 1.
// - the mode in force shows in the current-mode field, bits 7 to 5, which software polls.
// - mode and current-mode field change only after 11 consecutive recessive bits of bus idle.
// - six modes exist and exactly one is active at any time.
// - in initialization mode no frame is sent or received.
// - in initialization mode the error counters are cleared and interrupt flags are untouched.
// - configuration writes are ignored outside initialization mode.
// - initialization is entered only after any transmission in progress has finished.
// - the lock covers module control, baud and interrupt config, bus timing, filter and mask groups.
// - code 001 is disable mode, taken after 11 recessive bits, and frees the pins.
// - code 000 is normal mode with the transmit and receive pins in full use.
// - code 111 is listen-all mode: errors are ignored and partial data is kept for software.
// - disable requested during the initial idle wait cancels the pending transmission, aborting it.
module can_operating_mode_control #(
	parameter can_mode_pkg::code_t INIT_CODE = `MODE_INIT_DEFAULT,
	parameter can_mode_pkg::code_t LISTEN_ONLY_CODE = `MODE_LISTEN_ONLY_DEFAULT,
	parameter can_mode_pkg::code_t LOOPBACK_CODE = `MODE_LOOPBACK_DEFAULT
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [15:0] CTRL1_WDATA,
	input wire logic CTRL1_WE,
	output logic [15:0] CTRL1_RDATA,
	input wire logic [`CFG_GROUPS-1:0] CFG_WE,
	output logic [`CFG_GROUPS-1:0] CFG_WE_OK,
	input wire logic BIT_TICK,
	input wire logic RX_PIN,
	input wire logic TX_BUSY,
	input wire logic TX_PENDING,
	input wire logic ENGINE_ERROR,
	output logic REQ_UNSUPPORTED,
	output logic TX_ENABLE,
	output logic RX_ENABLE,
	output logic PINS_OWNED,
	output logic LOOPBACK,
	output logic ERROR_FRAMES_OFF,
	output logic ERR_CNT_CLEAR,
	output logic KEEP_PARTIAL_RX,
	output logic TX_ABORT,
	output logic tx_aborted_flag,
	output logic tx_request_clear
);
	typedef struct packed {
		logic [1:0] rx_sync;
		can_mode_pkg::code_t requested_mode_field;
		can_mode_pkg::mode_e mode;
		logic pend_wait;
		logic aborted;
		logic abort_pulse;
	} state_s;
	state_s q, next_q;
	logic bus_idle;
	can_mode_pkg::mode_e req_mode;
	logic req_ok;

	function automatic can_mode_pkg::code_t mode_code(input can_mode_pkg::mode_e m);
		unique case (m)
			can_mode_pkg::ST_INIT: mode_code = INIT_CODE;
			can_mode_pkg::ST_DISABLE: mode_code = `MODE_DISABLE;
			can_mode_pkg::ST_NORMAL: mode_code = `MODE_NORMAL;
			can_mode_pkg::ST_LISTEN_ONLY: mode_code = LISTEN_ONLY_CODE;
			can_mode_pkg::ST_LISTEN_ALL: mode_code = `MODE_LISTEN_ALL;
			can_mode_pkg::ST_LOOPBACK: mode_code = LOOPBACK_CODE;
			default: mode_code = INIT_CODE;
		endcase
	endfunction

	can_idle_detect idle_det (
		.CLK(CLK),
		.RST(RST),
		.BIT_TICK(BIT_TICK),
		.RX_BIT(q.rx_sync[1]),
		.IDLE(bus_idle)
	);

	// decode of requested code to mode; unlisted codes refused
	always_comb begin
		req_ok = 1'b1;
		req_mode = can_mode_pkg::ST_INIT;
		if (q.requested_mode_field == `MODE_NORMAL) begin
			req_mode = can_mode_pkg::ST_NORMAL;
		end else if (q.requested_mode_field == `MODE_DISABLE) begin
			req_mode = can_mode_pkg::ST_DISABLE;
		end else if (q.requested_mode_field == `MODE_LISTEN_ALL) begin
			req_mode = can_mode_pkg::ST_LISTEN_ALL;
		end else if (q.requested_mode_field == INIT_CODE) begin
			req_mode = can_mode_pkg::ST_INIT;
		end else if (q.requested_mode_field == LISTEN_ONLY_CODE) begin
			req_mode = can_mode_pkg::ST_LISTEN_ONLY;
		end else if (q.requested_mode_field == LOOPBACK_CODE) begin
			req_mode = can_mode_pkg::ST_LOOPBACK;
		end else begin
			req_ok = 1'b0;
		end
	end

	always_comb begin
		next_q = q;
		next_q.rx_sync = {q.rx_sync[0], RX_PIN};
		next_q.abort_pulse = 1'b0;
		if (CTRL1_WE) begin
			next_q.requested_mode_field = CTRL1_WDATA[`REQ_MODE_MSB:`REQ_MODE_LSB];
		end
		// transmission still waiting out its idle run after mode entry
		if (TX_PENDING && !TX_BUSY && !bus_idle && q.mode != can_mode_pkg::ST_INIT) begin
			next_q.pend_wait = 1'b1;
		end else begin
			next_q.pend_wait = 1'b0;
		end
		// abort repeats while the engine holds its request; the clear pulse drops it
		if (q.pend_wait && req_ok && req_mode == can_mode_pkg::ST_DISABLE && !bus_idle) begin
			next_q.aborted = 1'b1;
			next_q.abort_pulse = 1'b1;
			next_q.pend_wait = 1'b0;
		end
		// one mode register, switched only on idle bus
		// a busy transmitter holds off every switch, init included
		if (req_ok && req_mode != q.mode && bus_idle && !TX_BUSY) begin
			next_q.mode = req_mode;
		end
		if (CTRL1_WE && !CTRL1_WDATA[`REQ_MODE_MSB]) begin
			next_q.aborted = next_q.abort_pulse;
		end
	end

	// rx sync resets recessive so no false dominant bit follows reset
	always_ff @(posedge CLK) begin
		if (RST) begin
			q.rx_sync <= 2'h3;
			q.requested_mode_field <= `MODE_INIT_DEFAULT;
			q.mode <= can_mode_pkg::ST_INIT;
			q.pend_wait <= 1'b0;
			q.aborted <= 1'b0;
			q.abort_pulse <= 1'b0;
		end else begin
			q <= next_q;
		end
	end

	logic in_init;
	assign in_init = q.mode == can_mode_pkg::ST_INIT;

	always_comb begin
		CTRL1_RDATA = 16'h0000;
		CTRL1_RDATA[`REQ_MODE_MSB:`REQ_MODE_LSB] = q.requested_mode_field;
		CTRL1_RDATA[`CUR_MODE_MSB:`CUR_MODE_LSB] = mode_code(q.mode);
	end

	// all five lockable groups gated alike
	genvar g;
	generate
		for (g = 0; g < `CFG_GROUPS; g++) begin : lock_gen
			assign CFG_WE_OK[g] = CFG_WE[g] && in_init;
			grp_lock_a: assert property (@(posedge CLK) disable iff (RST)
				CFG_WE_OK[g] |-> CFG_WE[g] && in_init) else $error("group write passed outside init");
		end
	endgenerate

	assign REQ_UNSUPPORTED = !req_ok;
	assign TX_ENABLE = q.mode == can_mode_pkg::ST_NORMAL || q.mode == can_mode_pkg::ST_LOOPBACK;
	assign RX_ENABLE = !in_init && q.mode != can_mode_pkg::ST_DISABLE;
	assign PINS_OWNED = q.mode == can_mode_pkg::ST_NORMAL || q.mode == can_mode_pkg::ST_LISTEN_ONLY
		|| q.mode == can_mode_pkg::ST_LISTEN_ALL;
	assign LOOPBACK = q.mode == can_mode_pkg::ST_LOOPBACK;
	assign ERROR_FRAMES_OFF = q.mode == can_mode_pkg::ST_LISTEN_ONLY || q.mode == can_mode_pkg::ST_LISTEN_ALL;
	assign KEEP_PARTIAL_RX = q.mode == can_mode_pkg::ST_LISTEN_ALL && ENGINE_ERROR;
	assign ERR_CNT_CLEAR = in_init;
	assign TX_ABORT = q.abort_pulse;
	assign tx_request_clear = q.abort_pulse;
	assign tx_aborted_flag = q.aborted;

	// rule checks on the mode register and what it drives
	mode_hold_a: assert property (@(posedge CLK) disable iff (RST)
		(q.mode != $past(q.mode)) |-> $past(bus_idle)) else $error("mode changed without idle bus");
	field_hold_a: assert property (@(posedge CLK) disable iff (RST)
		!$past(bus_idle) |-> $stable(CTRL1_RDATA[7:5])) else $error("current mode field moved on busy bus");
	one_mode_a: assert property (@(posedge CLK) disable iff (RST)
		q.mode inside {can_mode_pkg::ST_INIT, can_mode_pkg::ST_DISABLE, can_mode_pkg::ST_NORMAL,
		can_mode_pkg::ST_LISTEN_ONLY, can_mode_pkg::ST_LISTEN_ALL, can_mode_pkg::ST_LOOPBACK})
		else $error("mode outside the six");
	init_no_tx_a: assert property (@(posedge CLK) disable iff (RST)
		in_init |-> !TX_ENABLE && !RX_ENABLE) else $error("traffic in init mode");
	init_pins_a: assert property (@(posedge CLK) disable iff (RST)
		in_init |-> !PINS_OWNED && !LOOPBACK) else $error("bus path open in init mode");
	init_clear_a: assert property (@(posedge CLK) disable iff (RST)
		ERR_CNT_CLEAR == (CTRL1_RDATA[7:5] == INIT_CODE)) else $error("counter clear out of step with init");
	cfg_lock_a: assert property (@(posedge CLK) disable iff (RST)
		(CFG_WE != 5'h00 && !in_init) |-> CFG_WE_OK == 5'h00) else $error("config write outside init");
	init_after_tx_a: assert property (@(posedge CLK) disable iff (RST)
		($past(TX_BUSY) && !$past(in_init)) |-> !in_init) else $error("init entered during tx");
	busy_hold_a: assert property (@(posedge CLK) disable iff (RST)
		TX_BUSY |=> q.mode == $past(q.mode)) else $error("mode switched during tx");
	disable_code_a: assert property (@(posedge CLK) disable iff (RST)
		q.mode == can_mode_pkg::ST_DISABLE |-> CTRL1_RDATA[7:5] == 3'h1 && !PINS_OWNED) else $error("disable code");
	disable_quiet_a: assert property (@(posedge CLK) disable iff (RST)
		q.mode == can_mode_pkg::ST_DISABLE |-> !TX_ENABLE && !RX_ENABLE && !LOOPBACK)
		else $error("traffic in disable mode");
	normal_pins_a: assert property (@(posedge CLK) disable iff (RST)
		q.mode == can_mode_pkg::ST_NORMAL |-> TX_ENABLE && RX_ENABLE && PINS_OWNED) else $error("normal pins");
	keep_partial_a: assert property (@(posedge CLK) disable iff (RST)
		(q.mode == can_mode_pkg::ST_LISTEN_ALL && ENGINE_ERROR) |-> KEEP_PARTIAL_RX && ERROR_FRAMES_OFF)
		else $error("listen-all lost partial data");
	abort_pair_a: assert property (@(posedge CLK) disable iff (RST)
		TX_ABORT |-> tx_request_clear && tx_aborted_flag) else $error("abort without flags");
	abort_wait_a: assert property (@(posedge CLK) disable iff (RST)
		TX_ABORT |-> $past(q.pend_wait) && !$past(bus_idle)) else $error("abort outside idle wait");
	abort_sticky_a: assert property (@(posedge CLK) disable iff (RST)
		(tx_aborted_flag && !(CTRL1_WE && !CTRL1_WDATA[`REQ_MODE_MSB])) |=> tx_aborted_flag)
		else $error("abort flag dropped");
	bad_code_a: assert property (@(posedge CLK) disable iff (RST)
		REQ_UNSUPPORTED |=> q.mode == $past(q.mode)) else $error("unsupported code switched mode");
	write_req_a: assert property (@(posedge CLK) disable iff (RST)
		CTRL1_WE |=> CTRL1_RDATA[10:8] == $past(CTRL1_WDATA[10:8])) else $error("request not stored");

	enter_normal_c: cover property (@(posedge CLK) disable iff (RST) in_init ##1 q.mode == can_mode_pkg::ST_NORMAL);
	enter_disable_c: cover property (@(posedge CLK) disable iff (RST) q.mode == can_mode_pkg::ST_DISABLE);
	abort_c: cover property (@(posedge CLK) disable iff (RST) TX_ABORT);
	loopback_c: cover property (@(posedge CLK) disable iff (RST) LOOPBACK);
	keep_partial_c: cover property (@(posedge CLK) disable iff (RST) KEEP_PARTIAL_RX);
endmodule

// *** can_bus_model.sv ***
// far-side model: other nodes on the bus plus the bit-rate divider of the bit engine
// assumes TRAFFIC comes from the bench, set and cleared at CLK rising edges
`timescale 1ns/1ps
module can_bus_model (
	input wire logic CLK,
	input wire logic RST,
	input wire logic TRAFFIC,
	output logic BIT_TICK,
	output logic RX_PIN
);
	logic [1:0] div;
	always_ff @(posedge CLK) begin
		if (RST) begin
			div <= 2'h0;
			RX_PIN <= 1'b1;
		end else begin
			div <= div + 2'h1;
			// level changes only at bit boundaries; recessive while nobody sends
			if (BIT_TICK) begin
				RX_PIN <= !TRAFFIC;
			end
		end
	end
	assign BIT_TICK = (div == 2'h3);
endmodule

// *** can_operating_mode_control_tb_top.sv ***
// self-checking bench of the operating-mode controller
// assumes can_mode_pkg, the design files and can_bus_model are compiled first
`timescale 1ns/1ps
`include "can_mode_cfg.svh"
module can_operating_mode_control_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] wdata = 16'h0;
	logic we = 1'b0;
	logic [4:0] cfg_we = 5'h1f;
	logic tx_busy = 1'b0;
	logic tx_pending = 1'b0;
	logic eng_err = 1'b0;
	logic traffic = 1'b0;
	logic tick, rx_pin, unsup, tx_en, rx_en, pins, lpbk, efo, errcl, keep, ab_p, ab_f, req_clr;
	logic [15:0] rdata;
	logic [4:0] cfg_ok;
	logic [1:0] seen;
	int n_errors = 0;
	int check_count = 0;
	always #4 clk = ~clk;
	can_bus_model can_bus_model_i (.CLK(clk), .RST(rst), .TRAFFIC(traffic), .BIT_TICK(tick), .RX_PIN(rx_pin));
	can_operating_mode_control can_operating_mode_control_i (.CLK(clk), .RST(rst), .CTRL1_WDATA(wdata),
		.CTRL1_WE(we), .CTRL1_RDATA(rdata), .CFG_WE(cfg_we), .CFG_WE_OK(cfg_ok), .BIT_TICK(tick),
		.RX_PIN(rx_pin), .TX_BUSY(tx_busy), .TX_PENDING(tx_pending), .ENGINE_ERROR(eng_err),
		.REQ_UNSUPPORTED(unsup), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .PINS_OWNED(pins), .LOOPBACK(lpbk),
		.ERROR_FRAMES_OFF(efo), .ERR_CNT_CLEAR(errcl), .KEEP_PARTIAL_RX(keep), .TX_ABORT(ab_p),
		.tx_aborted_flag(ab_f), .tx_request_clear(req_clr));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wr(input logic [2:0] code);
		@(posedge clk);
		wdata <= {5'h0, code, 8'h0};
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task automatic wait_mode(input logic [2:0] code);
		for (int i = 0; i < 300 && rdata[7:5] !== code; i++) begin
			@(posedge clk);
			#1;
		end
		chk(rdata[7:5], code);
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic t_normal;
		@(posedge clk);
		traffic <= 1'b1;
		wr(`MODE_NORMAL);
		pause(80);
		chk(rdata, 16'h0080);
		@(posedge clk);
		traffic <= 1'b0;
		wait_mode(`MODE_NORMAL);
		chk(cfg_ok, 5'h0);
		chk({tx_en, rx_en, pins, efo, errcl}, 5'h1c);
	endtask
	task automatic t_unsup;
		wr(3'h5);
		pause(60);
		chk(unsup, 1'b1);
		chk(rdata[7:5], `MODE_NORMAL);
	endtask
	task automatic t_listen_all;
		wr(`MODE_LISTEN_ALL);
		wait_mode(`MODE_LISTEN_ALL);
		chk({keep, efo}, 2'h1);
		@(posedge clk);
		eng_err <= 1'b1;
		pause(2);
		chk(keep, 1'b1);
		@(posedge clk);
		eng_err <= 1'b0;
		wr(`MODE_NORMAL);
		wait_mode(`MODE_NORMAL);
	endtask
	task automatic t_abort;
		@(posedge clk);
		traffic <= 1'b1;
		tx_pending <= 1'b1;
		pause(20);
		wr(`MODE_DISABLE);
		seen = 2'h0;
		repeat (10) begin
			@(posedge clk);
			#1;
			seen = seen | {ab_p, req_clr};
		end
		chk(seen, 2'h3);
		chk(ab_f, 1'b1);
		chk(rdata[7:5], `MODE_NORMAL);
		@(posedge clk);
		traffic <= 1'b0;
		tx_pending <= 1'b0;
		wait_mode(`MODE_DISABLE);
		chk(pins, 1'b0);
	endtask
	task automatic t_init;
		@(posedge clk);
		tx_busy <= 1'b1;
		wr(`MODE_INIT_DEFAULT);
		pause(80);
		chk(rdata[7:5], `MODE_DISABLE);
		@(posedge clk);
		tx_busy <= 1'b0;
		wait_mode(`MODE_INIT_DEFAULT);
		chk({tx_en, rx_en, errcl}, 3'h1);
		chk(cfg_ok, 5'h1f);
		@(posedge clk);
		cfg_we <= 5'h0a;
		pause(1);
		chk(cfg_ok, 5'h0a);
		@(posedge clk);
		cfg_we <= 5'h1f;
	endtask
	task automatic t_others;
		wr(`MODE_LOOPBACK_DEFAULT);
		wait_mode(`MODE_LOOPBACK_DEFAULT);
		chk(lpbk, 1'b1);
		chk(ab_f, 1'b0);
		wr(`MODE_LISTEN_ONLY_DEFAULT);
		wait_mode(`MODE_LISTEN_ONLY_DEFAULT);
		chk(lpbk, 1'b0);
		chk(efo, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		pause(1);
		chk(rdata, 16'h0480);
		chk(cfg_ok, 5'h1f);
		t_normal();
		t_unsup();
		t_listen_all();
		t_abort();
		t_init();
		t_others();
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
endmodule
